// *** cpu_bus_model.sv ***
// Processor bus model: issues I/O cycles and waits on ready
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model
  import io_cycle_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Processor pins
  output logic latched_addr_strobe_n,
  output logic io_region_hit,
  output logic writeNotRead,
  output logic [DEV_W-1:0] devDecode,
  // Ready line
  input wire logic readyOut_n,
  input wire logic readyOe,
  // Wait ran out
  output logic hung
);
  initial begin
    latched_addr_strobe_n = 1'b1;
    io_region_hit = 1'b0;
    writeNotRead = 1'b0;
    devDecode = 2'h0;
    hung = 1'b0;
  end
  // One cycle: strobe with status valid together, held until ready
  task automatic cycle(input logic wr, input logic [DEV_W-1:0] dev);
    int n;
    n = 0;
    @(negedge ref_clk);
    latched_addr_strobe_n = 1'b0;
    io_region_hit = 1'b1;
    writeNotRead = wr;
    devDecode = dev;
    @(negedge ref_clk);
    // Wait states last while ready stays high; bounded
    while (!(readyOe && !readyOut_n) && n < 200) begin
      n++;
      @(negedge ref_clk);
    end
    hung = (n >= 200);
    latched_addr_strobe_n = 1'b1;
    io_region_hit = 1'b0;
    writeNotRead = ~wr; // Released status shows no stale value
    devDecode = ~dev;
  endtask
endmodule // cpu_bus_model
`default_nettype wire

// *** io_cycle_control_logic.sv ***
// I/O cycle control logic: turns processor bus cycles into slave strobes
`timescale 1ns/1ps
`default_nettype none
module io_cycle_control_logic
  import io_cycle_pkg::*;
#(
  parameter int WAIT_OVERRIDE = 0  // Nonzero forces one common count
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clkEn,
  // Processor bus (pins, synchronised)
  input wire logic latched_addr_strobe_n,
  input wire logic io_region_hit,
  input wire logic writeNotRead,
  input wire logic [DEV_W-1:0] devDecode,
  input wire logic dram_outstanding,
  // Processor ready, two signals for the shared line, and cache enable
  output logic readyOut_n,
  output logic readyOe,
  output logic cache_allow_n,
  // Slave side
  output logic [NDEV-1:0] chipSel_n,
  output logic io_read_cmd_n,
  output logic io_write_cmd_n,
  output logic dataBufOe_n,
  output logic recoverActive
);
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Common count must fit the phase counter
  if (WAIT_OVERRIDE < 0 || WAIT_OVERRIDE >= (1 << CNT_W)) begin : g_bad_wait
    $error("WAIT_OVERRIDE out of range");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] syncA;  // First stage, read only by syncB
  logic [3:0] syncB;  // Stable copies
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      syncA <= 4'hf;
      syncB <= 4'hf;
    end else if (clkEn) begin
      syncA <= {latched_addr_strobe_n, ~io_region_hit, ~writeNotRead,
                ~dram_outstanding};
      syncB <= syncA;
    end
  end
  // Decode bits are stable while the strobe is; two stages too
  logic [DEV_W-1:0] devA;
  logic [DEV_W-1:0] devB;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      devA <= '0;
      devB <= '0;
    end else if (clkEn) begin
      devA <= devDecode;
      devB <= devA;
    end
  end
  logic ladsN;
  logic hit;
  logic isWrite;
  logic dramBusy;
  assign ladsN = syncB[3];
  assign hit = ~syncB[2];
  assign isWrite = ~syncB[1];
  assign dramBusy = ~syncB[0];

  // ----------------------------------------------------------------
  // Timing lookup
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] romWait;
  logic [CNT_W-1:0] romRecover;
  io_dev_timing_rom u_rom (
    .ref_clk(ref_clk),
    .clkEn(clkEn),
    .devSel(devB),
    .waitClks(romWait),
    .recoverClks(romRecover)
  );
  logic [CNT_W-1:0] cmdClks;
  // Common count trades speed for simpler decode
  assign cmdClks = (WAIT_OVERRIDE != 0) ? CNT_W'(WAIT_OVERRIDE) : romWait;

  // ----------------------------------------------------------------
  // Cycle state machine
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    IDLE   = 3'b000,
    PEND   = 3'b001,
    SETUP  = 3'b010,
    CMD    = 3'b011,
    HOLD   = 3'b100,
    FINISH = 3'b101
  } state_t;
  state_t state;
  logic [CNT_W-1:0] cnt;     // Shared phase counter
  logic [CNT_W-1:0] recCnt;  // Recovery countdown
  logic cycWrite;            // Direction sampled with strobe
  logic [DEV_W-1:0] cycDev;  // Latched device index
  logic startReq;
  logic armed;  // Strobe seen high since the last start
  // Start only with qualified hit and no DRAM cycle in flight
  // The synced strobe lags its pin by two clocks, so without the arm
  // a strobe still low just after ready would start the cycle again
  assign startReq = !ladsN && armed && hit && !dramBusy;

  // Re-armed once the strobe returns high between cycles
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      armed <= 1'b1;
    end else if (clkEn) begin
      if (ladsN) armed <= 1'b1;
      else if (state == IDLE && startReq) armed <= 1'b0;
    end
  end

  // Sequencing of one I/O cycle
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state <= IDLE;
      cnt <= '0;
      cycWrite <= 1'b0;
      cycDev <= '0;
    end else if (clkEn) begin
      case (state)
        IDLE: begin
          if (startReq) begin
            cycWrite <= isWrite;
            cycDev <= devB;
            state <= PEND;
          end
        end
        // One clock for the lookup to settle
        PEND: begin
          cnt <= CNT_W'(CS_SETUP_CLKS - 1);
          state <= SETUP;
        end
        // Select set-up; command waits for recovery to end
        SETUP: begin
          if (cnt != '0) begin
            cnt <= cnt - 1'b1;
          end else if (recCnt == '0) begin
            cnt <= (cmdClks == '0) ? '0 : cmdClks - 1'b1;
            state <= CMD;
          end
        end
        // Command active for cmdClks clocks, one at the least
        CMD: begin
          if (cnt != '0) begin
            cnt <= cnt - 1'b1;
          end else if (cycWrite) begin
            cnt <= CNT_W'(WRITE_HOLD_CLKS);
            state <= HOLD;
          end else begin
            state <= FINISH;
          end
        end
        // Write data hold before ready
        HOLD: begin
          if (cnt != '0) cnt <= cnt - 1'b1;
          else state <= FINISH;
        end
        // Ready pulse ends the processor cycle
        FINISH: state <= IDLE;
        default: state <= IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Recovery after reads
  // ----------------------------------------------------------------
  // Loaded as the read strobe rises; slaves float data later
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      recCnt <= '0;
    end else if (clkEn) begin
      if (state == CMD && cnt == '0 && !cycWrite) recCnt <= romRecover;
      else if (recCnt != '0) recCnt <= recCnt - 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  logic inCycle;
  logic cmdNext;
  assign inCycle = (state != IDLE) || startReq;
  assign cmdNext = (state == SETUP && cnt == '0 && recCnt == '0) ||
                   (state == CMD && cnt != '0);
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      readyOut_n <= 1'b1;
      readyOe <= 1'b0;
      cache_allow_n <= 1'b1;
      chipSel_n <= '1;
      io_read_cmd_n <= 1'b1;
      io_write_cmd_n <= 1'b1;
      dataBufOe_n <= 1'b1;
      recoverActive <= 1'b0;
    end else if (clkEn) begin
      // Drive ready only while servicing; release otherwise
      readyOe <= (state != IDLE) && (state != FINISH);
      readyOut_n <= !(state == HOLD && cnt == '0) &&
                    !(state == CMD && cnt == '0 && !cycWrite);
      // High marks every I/O access non-cacheable
      cache_allow_n <= inCycle;
      // Select held from start until ready returns
      for (int i = 0; i < NDEV; i++)
        chipSel_n[i] <= !((state != IDLE && state != FINISH && cycDev == DEV_W'(i)) ||
                          (state == IDLE && startReq && devB == DEV_W'(i)));
      io_read_cmd_n <= !(cmdNext && !cycWrite);
      io_write_cmd_n <= !(cmdNext && cycWrite);
      // Write data driven only once recovery clears
      dataBufOe_n <= !((state == SETUP || state == CMD || state == HOLD) &&
                       (!cycWrite || recCnt == '0));
      recoverActive <= (recCnt > 1) ||
                       (state == CMD && cnt == '0 && !cycWrite);
    end
  end
  // bind the processor; synchronised strobe assumes their timing
endmodule // io_cycle_control_logic
`default_nettype wire

// *** io_cycle_pkg.sv ***
// Package: constants for the I/O cycle control logic
package io_cycle_pkg;
  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int CMD_MIN_NS = 100;     // Shortest command width among slaves
  localparam int CMD_MAX_NS = 400;     // Longest command width among slaves
  localparam int FLOAT_NS = 40;        // Worst slave data float after read
  localparam int CS_SETUP_CLKS = 2;    // Chip select to command delay
  // Least times round up
  localparam int CMD_MIN_CLKS = (CMD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CMD_MAX_CLKS = (CMD_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLOAT_CLKS = (FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_HOLD_CLKS = 1;  // Ready delay after write strobe rises
  localparam int CNT_W = 5;
  // ----------------------------------------------------------------
  // Device table
  // ----------------------------------------------------------------
  localparam int NDEV = 4;
  localparam int DEV_W = 2;
endpackage : io_cycle_pkg

// *** io_cycle_sva.sv ***
// Checker: timing relations at the I/O cycle control ports
`timescale 1ns/1ps
`default_nettype none
module io_cycle_sva
  import io_cycle_pkg::*;
#(
  parameter int WAIT_OVERRIDE = 0
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Watched outputs
  input wire logic readyOut_n,
  input wire logic readyOe,
  input wire logic cache_allow_n,
  input wire logic [NDEV-1:0] chipSel_n,
  input wire logic io_read_cmd_n,
  input wire logic io_write_cmd_n,
  input wire logic recoverActive
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Shortest legal read strobe: common count, else fastest slave
  localparam int MIN_RD = (WAIT_OVERRIDE != 0) ? WAIT_OVERRIDE : CMD_MIN_CLKS;
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  logic [7:0] rdWidth; // Cycles the read strobe has been low
  // Counts strobe width so a short strobe shows at its release
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) rdWidth <= 8'h00;
    else if (io_read_cmd_n) rdWidth <= 8'h00;
    else rdWidth <= rdWidth + 8'h01;
  end
  sequence cmdStart;
    $fell(io_read_cmd_n) || $fell(io_write_cmd_n);
  endsequence
  sequence cmdLow;
    !io_read_cmd_n || !io_write_cmd_n;
  endsequence
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_sel_before_cmd: assert property (cmdStart |-> $past(chipSel_n, 2) != 4'hF)
    else $error("strobe began less than two clocks after select");
  a_strobe_exclusive: assert property (!(!io_read_cmd_n && !io_write_cmd_n))
    else $error("read and write strobes low together");
  a_ready_owned: assert property (!readyOut_n |-> readyOe ##1 readyOut_n)
    else $error("ready low without drive or longer than a cycle");
  a_cmd_after_recover: assert property (cmdStart |-> !$past(recoverActive))
    else $error("strobe began during recovery");
  a_recover_after_read: assert property ($rose(io_read_cmd_n) |-> ##[0:2] recoverActive)
    else $error("no recovery after read");
  a_cache_off: assert property ((chipSel_n != 4'hF) |-> cache_allow_n)
    else $error("cacheable during I/O access");
  a_select_held: assert property (cmdLow |-> (chipSel_n != 4'hF) && $stable(chipSel_n))
    else $error("select moved during command");
  a_read_width: assert property ($rose(io_read_cmd_n) |-> rdWidth >= MIN_RD)
    else $error("read strobe too short");
  a_ready_after_write: assert property (!readyOut_n |-> io_read_cmd_n && $past(io_write_cmd_n))
    else $error("ready before write strobe rose");
endmodule // io_cycle_sva
bind io_cycle_control_logic io_cycle_sva #(.WAIT_OVERRIDE(WAIT_OVERRIDE)) u_sva (
  .ref_clk(ref_clk), .rstn(rstn), .readyOut_n(readyOut_n), .readyOe(readyOe),
  .cache_allow_n(cache_allow_n), .chipSel_n(chipSel_n), .io_read_cmd_n(io_read_cmd_n),
  .io_write_cmd_n(io_write_cmd_n), .recoverActive(recoverActive));
`default_nettype wire

// *** io_dev_timing_rom.sv ***
// Per-device wait-state lookup and one common recovery count, with registered output
`timescale 1ns/1ps
`default_nettype none
module io_dev_timing_rom
  import io_cycle_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  input wire logic clkEn,
  // Lookup
  input wire logic [DEV_W-1:0] devSel,
  output logic [CNT_W-1:0] waitClks,
  output logic [CNT_W-1:0] recoverClks
);
  // ----------------------------------------------------------------
  // Constant table
  // ----------------------------------------------------------------
  // Table spreads command widths from fastest to slowest slave
  function automatic logic [CNT_W-1:0] waitOf(input logic [DEV_W-1:0] d);
    case (d)
      2'h0: waitOf = CNT_W'(CMD_MIN_CLKS);
      2'h1: waitOf = CNT_W'(CMD_MIN_CLKS * 2);
      2'h2: waitOf = CNT_W'(CMD_MIN_CLKS * 3);
      default: waitOf = CNT_W'(CMD_MAX_CLKS);
    endcase
  endfunction

  // Registered read, no reset needed for a lookup
  always_ff @(posedge ref_clk) begin
    if (clkEn) begin
      waitClks <= waitOf(devSel);
      recoverClks <= CNT_W'(FLOAT_CLKS);
    end
  end
endmodule // io_dev_timing_rom
`default_nettype wire

// *** testbench.sv ***
// Testbench for the I/O cycle control logic
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import io_cycle_pkg::*;
  logic ref_clk, rstn, clkEn, dram_outstanding, hung;
  logic ladsN, hit, wnr, readyOut_n, readyOe, cache_allow_n;
  logic io_read_cmd_n, io_write_cmd_n, dataBufOe_n, recoverActive;
  logic [DEV_W-1:0] dev;
  logic [NDEV-1:0] chipSel_n, selSeen;
  logic rdSeen, wrSeen, recSeen, bufSeen, cacheBad;
  logic clrSeen = 1'b0;
  int error_cnt = 0;
  int tests_run = 0;
  // Rows: write flag, device, expected select
  typedef struct packed {logic wr; logic [1:0] dv; logic [3:0] sel;} row_t;
  row_t rows [8] = '{'{1'b0, 2'h0, 4'hE}, '{1'b1, 2'h0, 4'hE}, '{1'b0, 2'h1, 4'hD},
    '{1'b0, 2'h2, 4'hB}, '{1'b1, 2'h3, 4'h7}, '{1'b1, 2'h1, 4'hD}, '{1'b0, 2'h3, 4'h7},
    '{1'b1, 2'h2, 4'hB}};
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  cpu_bus_model u_cpu (.ref_clk(ref_clk), .latched_addr_strobe_n(ladsN), .io_region_hit(hit),
    .writeNotRead(wnr), .devDecode(dev), .readyOut_n(readyOut_n), .readyOe(readyOe), .hung(hung));
  io_cycle_control_logic #(.WAIT_OVERRIDE(1)) u_dut (.ref_clk(ref_clk), .rstn(rstn),
    .clkEn(clkEn), .latched_addr_strobe_n(ladsN), .io_region_hit(hit), .writeNotRead(wnr),
    .devDecode(dev), .dram_outstanding(dram_outstanding), .readyOut_n(readyOut_n),
    .readyOe(readyOe), .cache_allow_n(cache_allow_n), .chipSel_n(chipSel_n),
    .io_read_cmd_n(io_read_cmd_n), .io_write_cmd_n(io_write_cmd_n),
    .dataBufOe_n(dataBufOe_n), .recoverActive(recoverActive));
  // Monitor: what each cycle showed at the slave side
  always @(negedge ref_clk) begin
    if (clrSeen) begin
      selSeen = 4'hF;
      rdSeen = 1'b0;
      wrSeen = 1'b0;
      recSeen = 1'b0;
      bufSeen = 1'b0;
      cacheBad = 1'b0;
    end else begin
      if (chipSel_n != 4'hF) selSeen = chipSel_n;
      if (chipSel_n != 4'hF && !cache_allow_n) cacheBad = 1'b1;
      if (!io_read_cmd_n) rdSeen = 1'b1;
      if (!io_write_cmd_n) wrSeen = 1'b1;
      if (recoverActive) recSeen = 1'b1;
      if (!dataBufOe_n) bufSeen = 1'b1;
    end
  end
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  // The monitor alone writes the records; this asks it to clear them
  task automatic clear_seen();
    clrSeen <= 1'b1;
    @(negedge ref_clk);
    clrSeen <= 1'b0;
  endtask
  task automatic tally_and_finish();
    if (error_cnt == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    rstn = 1'b0;
    clkEn = 1'b1;
    dram_outstanding = 1'b0;
    repeat (5) @(negedge ref_clk);
    check("reset_oe", 8'h00, 8'(readyOe));
    check("reset_rdy", 8'h01, 8'(readyOut_n));
    check("reset_sel", 8'h0F, 8'(chipSel_n));
    check("reset_cmd", 8'h03, 8'({io_read_cmd_n, io_write_cmd_n}));
    check("reset_rec", 8'h00, 8'(recoverActive));
    rstn = 1'b1;
    // Ordinary cycles, back to back, read and write on every device
    for (int i = 0; i < 8; i++) begin
      clear_seen();
      u_cpu.cycle(rows[i].wr, rows[i].dv);
      // One more clock so recovery after a read is recorded
      @(negedge ref_clk);
      check("hang", 8'h00, 8'(hung));
      check("recover", 8'(!rows[i].wr), 8'(recSeen));
      check("buffer", 8'h01, 8'(bufSeen));
      check("cacheable", 8'h00, 8'(cacheBad));
      check("select", 8'(rows[i].sel), 8'(selSeen));
      check("read", 8'(!rows[i].wr), 8'(rdSeen));
      check("write", 8'(rows[i].wr), 8'(wrSeen));
    end
    // Outstanding memory cycle holds off the start until it clears
    clear_seen();
    dram_outstanding = 1'b1;
    fork
      u_cpu.cycle(1'b0, 2'h2);
      begin
        repeat (12) @(negedge ref_clk);
        check("dram_sel", 8'h0F, 8'(selSeen));
        dram_outstanding = 1'b0;
      end
    join
    check("dram_hang", 8'h00, 8'(hung));
    check("dram_done", 8'h0B, 8'(selSeen));
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
